/* File: rtl/uart_tx_enable_format.sv */
// Serial transmitter with enable control, frame format and APB registers
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// RQ1 - All three enables set: drive output pin, use input pin for receive.
// RQ2 - Output line sits high whenever no frame is shifting.
// RQ3 - Global disable releases both pins and empties the data buffer.
// RQ4 - Disable clears enables, break, receive flags; sets idle and empty.
// RQ5 - Disable keeps all other control and divisor bits unchanged.
// RQ6 - Global disable aborts any frame at once, back to reset state.
// RQ7 - Data length bit picks 8 or 9 data bits; set means 9.
// RQ8 - Parity enable switches parity; parity type picks odd or even.
// RQ9 - Parity takes last data position: 7 or 8 data bits remain.
// RQ10 - With address detect, the data MSB flags an address character.
// RQ11 - Stop count one or two applies to transmit only.
// RQ12 - In 9-bit mode the ninth bit comes from a control bit.
// RQ13 - Shift register reloads only after stop bits and if data waits.
// RQ14 - Sending needs enable, data and baud clock; data may come first.
// RQ15 - Dropping transmit enable mid frame stops and resets transmitter.
// RQ16 - Data bits leave least significant bit first.
// RQ17 - Data writes are ignored while transmit-empty reads zero.
// RQ18 - Transmit-empty clears only on status access then data write.
// RQ19 - Transmit-empty set when holding free; request if its enable set.
// RQ20 - Busy write waits in holding; idle write starts at once.
// RQ21 - Transmitter-idle sets when a frame or break frame finishes.
// RQ22 - Baud is clock over 64 or 16 times divisor plus one.
// RQ23 - Reset format is eight data bits, no parity, one stop bit.
// RQ24 - Transmitter-idle clears on the same status-then-write pair.
// RQ25 - Parity makes ones count even in even mode, odd in odd.
module uart_tx_enable_format
   import uart_tx_pkg::*;
(
   // Clock, reset and freeze
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [uart_tx_pkg::ADDR_W-1:0] paddr,
   input wire logic [uart_tx_pkg::DATA_W-1:0] pwdata,
   output logic [uart_tx_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial pins
   output logic serial_out_pin,
   output logic serial_out_oe_n,
   input wire logic serial_in_pin,
   output logic serial_in_select,
   // Transmit-empty request
   output logic tx_empty_irq
);
   logic [7:0] ctrl1_ff;
   logic [7:0] nxt_ctrl1;
   logic [7:0] ctrl2_ff;
   logic [7:0] nxt_ctrl2;
   logic [7:0] baud_ff;
   logic [7:0] hold_ff;
   logic hold_full_ff;
   logic txe_ff;
   logic tidle_ff;
   logic armed_ff;
   tx_state_t state_ff;
   logic [8:0] shift_ff;
   logic [3:0] bits_ff;
   logic stop_ff;
   logic [5:0] pre_ff;
   logic [7:0] div_ff;
   logic line_ff;
   logic [DATA_W-1:0] prdata_ff;
   logic acc;
   logic wr_acc;
   logic mapped;
   logic data_wr;
   logic take;
   logic direct;
   logic reload;
   logic frame_end;
   logic tick;
   logic gen;
   logic tx_run;
   logic brk;
   logic [5:0] pre_last;
   logic [3:0] last_bit;
   logic [7:0] status;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Build the shifted word from a data byte and the format bits
   function automatic logic [8:0] frame_word(input logic [7:0] d);
      logic [8:0] w;
      w = {ctrl1_ff[C1_TX_NINTH] & ctrl1_ff[C1_DATA_LEN], d}; // RQ12 RQ7
      if (ctrl1_ff[C1_PAR_EN]) // RQ8
      begin
         if (ctrl1_ff[C1_DATA_LEN])
            w[8] = ctrl1_ff[C1_PAR_TYPE] ^ (^d); // RQ9 RQ25
         else
            w[7] = ctrl1_ff[C1_PAR_TYPE] ^ (^d[6:0]); // RQ9 RQ25
      end
      // The top data bit doubles as the address flag; no change here
      return w; // RQ10
   endfunction

   assign gen = ctrl1_ff[C1_GLOBAL_EN];
   assign brk = ctrl1_ff[C1_BREAK];
   assign tx_run = gen & ctrl2_ff[C2_TX_EN];
   assign acc = psel & penable;
   assign wr_acc = acc & pwrite & ce;
   assign pready = ce;
   assign mapped = (paddr == ADDR_CTRL_ONE) || (paddr == ADDR_CTRL_TWO)
      || (paddr == ADDR_BAUD) || (paddr == ADDR_STATUS)
      || (paddr == ADDR_DATA);
   assign pslverr = acc & ~mapped;
   assign prdata = prdata_ff;

   // Pin function select
   assign serial_out_oe_n = ~tx_run; // RQ1 RQ3 RQ15
   assign serial_in_select = gen & ctrl2_ff[C2_RX_EN]; // RQ1 RQ3
   assign serial_out_pin = line_ff;
   assign tx_empty_irq = txe_ff & ctrl2_ff[C2_TXE_IE] & gen; // RQ19

   // Control register one; break request dies with the global enable
   always_comb
   begin
      nxt_ctrl1 = ctrl1_ff;
      if (wr_acc && paddr == ADDR_CTRL_ONE)
         nxt_ctrl1 = pwdata[7:0];
      nxt_ctrl1[C1_RX_NINTH] = 1'b0;
      if (!nxt_ctrl1[C1_GLOBAL_EN])
         nxt_ctrl1[C1_BREAK] = 1'b0; // RQ4 RQ5
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl1_ff <= CTRL_ONE_RST; // RQ23
      else if (ce)
         ctrl1_ff <= nxt_ctrl1;
   end

   // Control register two; both enables drop while disabled
   always_comb
   begin
      nxt_ctrl2 = ctrl2_ff;
      if (wr_acc && paddr == ADDR_CTRL_TWO)
         nxt_ctrl2 = pwdata[7:0];
      if (!nxt_ctrl1[C1_GLOBAL_EN])
      begin
         nxt_ctrl2[C2_TX_EN] = 1'b0; // RQ4 RQ5
         nxt_ctrl2[C2_RX_EN] = 1'b0; // RQ4
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl2_ff <= CTRL_TWO_RST;
      else if (ce)
         ctrl2_ff <= nxt_ctrl2;
   end

   a_enables_off: assert property (!gen |-> !ctrl2_ff[C2_TX_EN] // RQ4
      && !ctrl2_ff[C2_RX_EN] && !brk)
      else $error("enable or break left set while disabled");

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         baud_ff <= BAUD_RST;
      else if (ce && wr_acc && paddr == ADDR_BAUD)
         baud_ff <= pwdata[7:0]; // RQ5
   end

   // Status register image; receive side flags idle and clear
   always_comb
   begin
      status = 8'h00;
      status[SR_TX_EMPTY] = txe_ff;
      status[SR_TX_IDLE] = tidle_ff;
      status[SR_RX_IDLE] = 1'b1; // RQ4
      status[SR_RX_READY] = 1'b0; // RQ4
      status[SR_OVERRUN] = 1'b0;
      status[SR_FRAMING] = 1'b0;
      status[SR_PARITY] = 1'b0;
      status[SR_NOISE] = 1'b0;
   end

   // Read data captured in the setup phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_ff <= 32'h0000_0000;
      else if (ce && psel && !penable && !pwrite)
      begin
         unique case (paddr)
            ADDR_CTRL_ONE: prdata_ff <= {24'h00_0000, ctrl1_ff};
            ADDR_CTRL_TWO: prdata_ff <= {24'h00_0000, ctrl2_ff};
            ADDR_BAUD: prdata_ff <= {24'h00_0000, baud_ff};
            ADDR_STATUS: prdata_ff <= {24'h00_0000, status};
            default: prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // Write acceptance for the data register
   assign data_wr = wr_acc && paddr == ADDR_DATA;
   assign take = data_wr & armed_ff & txe_ff; // RQ17 RQ18
   assign direct = take & tx_run & (state_ff == TX_IDLE) & ~brk; // RQ20
   assign reload = tx_run & hold_full_ff
      & ((state_ff == TX_IDLE) | frame_end); // RQ13 RQ14

   // Status access arms the clearing pair; the data write disarms it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         armed_ff <= 1'b0;
      else if (ce)
      begin
         if (acc && paddr == ADDR_STATUS)
            armed_ff <= 1'b1; // RQ18
         else if (acc && paddr == ADDR_DATA)
            armed_ff <= 1'b0; // RQ18
      end
   end

   // Holding register and transmit-empty flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hold_ff <= 8'h00;
         hold_full_ff <= 1'b0;
         txe_ff <= 1'b1;
      end
      else if (ce)
      begin
         if (!gen)
         begin
            hold_full_ff <= 1'b0; // RQ3
            txe_ff <= 1'b1; // RQ4
         end
         else if (reload)
         begin
            hold_full_ff <= 1'b0;
            txe_ff <= 1'b1; // RQ19
         end
         else if (take && !direct)
         begin
            hold_ff <= pwdata[7:0]; // RQ14 RQ20
            hold_full_ff <= 1'b1;
            txe_ff <= 1'b0; // RQ18
         end
      end
   end

   a_write_ignored: assert property (ce && gen && data_wr && !txe_ff // RQ17
      |=> $stable(hold_ff) && (hold_full_ff || $past(reload)))
      else $error("data write taken while not empty");

   a_empty_holds: assert property (txe_ff && gen && ce && !take // RQ18
      |=> txe_ff)
      else $error("empty flag cleared without the ordered pair");

   // Transmitter idle flag; a set beats a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tidle_ff <= 1'b1;
      else if (ce)
      begin
         if (!gen)
            tidle_ff <= 1'b1; // RQ4
         else if (frame_end && !reload)
            tidle_ff <= 1'b1; // RQ21
         else if (!tx_run && state_ff != TX_IDLE)
            tidle_ff <= 1'b1; // RQ15
         else if (take)
            tidle_ff <= 1'b0; // RQ24
      end
   end

   // Baud generator, restarted at each frame so bits are whole
   assign pre_last = ctrl2_ff[C2_SPEED] ? PRE_LAST_HIGH : PRE_LAST_LOW;
   assign tick = (state_ff != TX_IDLE) && (pre_ff == pre_last)
      && (div_ff == baud_ff); // RQ22

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_ff <= 6'h00;
         div_ff <= 8'h00;
      end
      else if (ce)
      begin
         if (state_ff == TX_IDLE || !tx_run)
         begin
            pre_ff <= 6'h00;
            div_ff <= 8'h00;
         end
         else if (pre_ff == pre_last)
         begin
            pre_ff <= 6'h00; // RQ22
            div_ff <= (div_ff == baud_ff) ? 8'h00 : div_ff + 8'h01;
         end
         else
            pre_ff <= pre_ff + 6'h01;
      end
   end

   // Transmit sequencer
   assign last_bit = ctrl1_ff[C1_DATA_LEN] ? LAST_BIT_NINE
      : LAST_BIT_EIGHT; // RQ7
   assign frame_end = (state_ff == TX_STOP) && tick
      && (stop_ff == ctrl1_ff[C1_STOP_CNT]); // RQ11

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= TX_IDLE;
         shift_ff <= 9'h000;
         bits_ff <= 4'h0;
         stop_ff <= 1'b0;
      end
      else if (ce)
      begin
         if (!tx_run)
            state_ff <= TX_IDLE; // RQ6 RQ15
         else
         begin
            unique case (state_ff)
               TX_IDLE:
               begin
                  bits_ff <= 4'h0;
                  stop_ff <= 1'b0;
                  if (direct)
                  begin
                     shift_ff <= frame_word(pwdata[7:0]); // RQ20
                     state_ff <= TX_START;
                  end
                  else if (reload)
                  begin
                     shift_ff <= frame_word(hold_ff); // RQ14
                     state_ff <= TX_START;
                  end
                  else if (brk)
                  begin
                     shift_ff <= 9'h000;
                     state_ff <= TX_START;
                  end
               end
               TX_START:
                  if (tick)
                     state_ff <= brk ? TX_BREAK : TX_DATA;
               TX_DATA:
                  if (tick)
                  begin
                     shift_ff <= {1'b0, shift_ff[8:1]}; // RQ16
                     bits_ff <= bits_ff + 4'h1;
                     if (bits_ff == last_bit)
                     begin
                        bits_ff <= 4'h0;
                        state_ff <= TX_STOP;
                     end
                  end
               TX_BREAK:
                  if (tick)
                  begin
                     bits_ff <= bits_ff + 4'h1;
                     if (bits_ff == BREAK_LAST)
                     begin
                        bits_ff <= 4'h0;
                        if (!brk)
                           state_ff <= TX_STOP; // RQ21
                     end
                  end
               TX_STOP:
                  if (tick)
                  begin
                     stop_ff <= 1'b1;
                     if (frame_end)
                     begin
                        stop_ff <= 1'b0;
                        if (reload)
                        begin
                           shift_ff <= frame_word(hold_ff); // RQ13
                           state_ff <= TX_START;
                        end
                        else if (brk)
                           state_ff <= TX_START;
                        else
                           state_ff <= TX_IDLE;
                     end
                  end
               default: state_ff <= TX_IDLE;
            endcase
         end
      end
   end

   a_abort_frame: assert property (ce && !tx_run // RQ6 RQ15
      |=> state_ff == TX_IDLE)
      else $error("transmitter kept running after enable dropped");

   a_direct_start: assert property (ce && direct // RQ20
      |=> state_ff == TX_START && txe_ff && !hold_full_ff)
      else $error("idle write did not start a frame at once");

   a_reload_after_stop: assert property (ce && frame_end && reload // RQ13
      |=> state_ff == TX_START && !hold_full_ff && txe_ff)
      else $error("waiting data not reloaded after stop bits");

   a_no_early_load: assert property (ce && state_ff == TX_DATA // RQ13
      && tx_run && hold_full_ff |=> hold_full_ff)
      else $error("holding register drained during a frame");

   a_idle_sets: assert property (ce && gen && frame_end && !reload // RQ21
      |=> tidle_ff)
      else $error("idle flag not set at frame end");

   // Line level follows the sequencer state one cycle later
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         line_ff <= 1'b1;
      else if (ce)
      begin
         if (!tx_run)
            line_ff <= 1'b1; // RQ2
         else if (state_ff == TX_START || state_ff == TX_BREAK)
            line_ff <= 1'b0;
         else if (state_ff == TX_DATA)
            line_ff <= shift_ff[0]; // RQ16
         else
            line_ff <= 1'b1; // RQ2
      end
   end

   a_line_idle_high: assert property (ce && (state_ff == TX_IDLE // RQ2
      || state_ff == TX_STOP) |=> line_ff)
      else $error("line not high outside a frame");

   a_lsb_first: assert property (ce && state_ff == TX_DATA && tx_run // RQ16
      |=> line_ff == $past(shift_ff[0]))
      else $error("line does not carry the low shift bit");

endmodule

/* File: rtl/uart_tx_pkg.sv */
// Constants and types shared by the serial transmitter block
package uart_tx_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;

   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
   localparam logic [7:0] ADDR_BAUD = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_DATA = 8'h10;

   // serial_control_one fields
   localparam int C1_GLOBAL_EN = 7;
   localparam int C1_DATA_LEN = 6;
   localparam int C1_PAR_EN = 5;
   localparam int C1_PAR_TYPE = 4;
   localparam int C1_STOP_CNT = 3;
   localparam int C1_BREAK = 2;
   localparam int C1_RX_NINTH = 1;
   localparam int C1_TX_NINTH = 0;

   // serial_control_two fields
   localparam int C2_TX_EN = 7;
   localparam int C2_RX_EN = 6;
   localparam int C2_SPEED = 5;
   localparam int C2_ADDR_DET = 4;
   localparam int C2_TXE_IE = 0;

   // serial_status_register fields
   localparam int SR_TX_EMPTY = 0;
   localparam int SR_TX_IDLE = 1;
   localparam int SR_RX_IDLE = 2;
   localparam int SR_RX_READY = 3;
   localparam int SR_OVERRUN = 4;
   localparam int SR_FRAMING = 5;
   localparam int SR_PARITY = 6;
   localparam int SR_NOISE = 7;

   // Reset values: disabled, 8 data bits, no parity, one stop bit
   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] CTRL_TWO_RST = 8'h00;
   localparam logic [7:0] BAUD_RST = 8'h00;

   // Baud prescale factors and frame lengths
   localparam int PRESCALE_LOW = 64;
   localparam int PRESCALE_HIGH = 16;
   localparam logic [5:0] PRE_LAST_LOW = 6'(PRESCALE_LOW - 1);
   localparam logic [5:0] PRE_LAST_HIGH = 6'(PRESCALE_HIGH - 1);
   localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
   localparam logic [3:0] LAST_BIT_NINE = 4'h8;
   localparam logic [3:0] BREAK_LAST = 4'hC;

   typedef enum logic [2:0] {
      TX_IDLE,
      TX_START,
      TX_DATA,
      TX_BREAK,
      TX_STOP
   } tx_state_t;
endpackage

/* File: testbench/test_uart_tx_enable_format.sv */
// Self-checking bench for the serial transmitter block
`timescale 1ns/1ps
module test_uart_tx_enable_format
   import uart_tx_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, err;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rdata;
   logic pready, pslverr, serial_out_pin, serial_out_oe_n;
   logic serial_in_pin, serial_in_select, tx_empty_irq;
   logic [8:0] got;
   int count, bit_len, nbits, el, c0;
   int cyc = 0;
   int bad_count = 0;
   int n_compared = 0;

   uart_tx_enable_format uart_tx_enable_format_i (
      .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n),
      .serial_in_pin(serial_in_pin), .serial_in_select(serial_in_select),
      .tx_empty_irq(tx_empty_irq));

   uart_line_model uart_line_model_i (
      .pclk(pclk), .line(serial_out_pin), .rx_line(serial_in_pin),
      .bit_len(bit_len), .nbits(nbits), .got(got), .count(count));

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   always @(posedge pclk) cyc <= cyc + 1;

   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] s);
      n_compared++;
      if (s !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, s);
      end
   endtask

   task fail_wait;
      bad_count++;
      $display("mismatch wait expected done seen timeout");
      end_sim;
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Outputs launched by this edge are looked at once settled
      @(negedge pclk);
      if (k >= 20)
         fail_wait;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask

   task rdc(input string n, input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0);
      chk(n, {24'h0, exp}, rdata);
   endtask

   // Status access then data write, the accepted pairing
   task send(input logic [7:0] b);
      apb(1'b0, ADDR_STATUS, 32'h0);
      wr(ADDR_DATA, b);
   endtask

   task wait_idle(input int t0);
      int k;
      k = 0;
      do
      begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         k++;
      end
      while (rdata[SR_TX_IDLE] !== 1'b1 && k < 3000);
      el = cyc - t0;
      if (k >= 3000)
         fail_wait;
   endtask

   task send_chk(input logic [7:0] c1, input logic [7:0] b, input int nb,
                 input int stops, input int len, input logic [8:0] exp);
      int t0, nt;
      wr(ADDR_CTRL_ONE, c1);
      nbits = nb;
      bit_len = len;
      c0 = count;
      nt = (1 + nb + stops) * len;
      send(b);
      t0 = cyc;
      rdc("status busy", ADDR_STATUS, 8'h05);
      wait_idle(t0);
      chk("frame", {23'h0, exp}, {23'h0, got});
      chk("frames", c0 + 1, count);
      n_compared++;
      if (el < nt || el > nt + 10)
      begin
         bad_count++;
         $display("mismatch frame time expected %0d seen %0d", nt, el);
      end
   endtask

   task t_reset;
      chk("line", 1, serial_out_pin);
      chk("oe_n", 1, serial_out_oe_n);
      chk("in select", 0, serial_in_select);
      chk("irq", 0, tx_empty_irq);
      rdc("ctrl one", ADDR_CTRL_ONE, 8'h00);
      rdc("ctrl two", ADDR_CTRL_TWO, 8'h00);
      rdc("baud", ADDR_BAUD, 8'h00);
      rdc("status", ADDR_STATUS, 8'h07);
   endtask

   task t_formats;
      wr(ADDR_CTRL_ONE, 8'h80);
      wr(ADDR_CTRL_TWO, 8'hE0);
      chk("oe_n", 0, serial_out_oe_n);
      chk("in select", 1, serial_in_select);
      send_chk(8'h80, 8'hA5, 8, 1, 16, 9'h0A5);
      send_chk(8'hC1, 8'h3C, 9, 1, 16, 9'h13C);
      send_chk(8'hA0, 8'h07, 8, 1, 16, 9'h087);
      send_chk(8'hB0, 8'h07, 8, 1, 16, 9'h007);
      send_chk(8'hE0, 8'h01, 9, 1, 16, 9'h101);
      send_chk(8'h88, 8'h5A, 8, 2, 16, 9'h05A);
      wr(ADDR_CTRL_TWO, 8'hF0);
      rdc("ctrl two", ADDR_CTRL_TWO, 8'hF0);
      send_chk(8'h80, 8'h80, 8, 1, 16, 9'h080);
      wr(ADDR_CTRL_TWO, 8'hC0);
      send_chk(8'h80, 8'h3C, 8, 1, 64, 9'h03C);
      wr(ADDR_BAUD, 8'h01);
      send_chk(8'h80, 8'hC3, 8, 1, 128, 9'h0C3);
      wr(ADDR_BAUD, 8'h00);
   endtask

   task t_buffer;
      wr(ADDR_CTRL_TWO, 8'hE1);
      bit_len = 16;
      c0 = count;
      send(8'h11);
      chk("irq", 1, tx_empty_irq);
      send(8'h22);
      chk("irq", 0, tx_empty_irq);
      rdc("status", ADDR_STATUS, 8'h04);
      wr(ADDR_DATA, 8'h33);
      wait_idle(cyc);
      chk("frame", 9'h022, got);
      chk("frames", c0 + 2, count);
      chk("irq", 1, tx_empty_irq);
      send(8'h44);
      wr(ADDR_DATA, 8'h66);
      wait_idle(cyc);
      chk("frame", 9'h044, got);
      chk("frames", c0 + 3, count);
   endtask

   task t_late_enable;
      wr(ADDR_CTRL_TWO, 8'h60);
      send(8'h96);
      repeat (40) @(posedge pclk);
      chk("line", 1, serial_out_pin);
      chk("oe_n", 1, serial_out_oe_n);
      wr(ADDR_CTRL_TWO, 8'hE0);
      wait_idle(cyc);
      chk("frame", 9'h096, got);
      send(8'h0F);
      repeat (50) @(posedge pclk);
      wr(ADDR_CTRL_TWO, 8'h60);
      repeat (2) @(posedge pclk);
      chk("line", 1, serial_out_pin);
      chk("oe_n", 1, serial_out_oe_n);
      rdc("status", ADDR_STATUS, 8'h07);
      repeat (300) @(posedge pclk);
   endtask

   task t_abort;
      wr(ADDR_CTRL_TWO, 8'hE0);
      wr(ADDR_BAUD, 8'h01);
      wr(ADDR_CTRL_ONE, 8'hB8);
      send(8'hAA);
      send(8'h55);
      wr(ADDR_CTRL_ONE, 8'hBC);
      wr(ADDR_CTRL_ONE, 8'h3C);
      repeat (2) @(posedge pclk);
      chk("line", 1, serial_out_pin);
      chk("oe_n", 1, serial_out_oe_n);
      chk("in select", 0, serial_in_select);
      rdc("status", ADDR_STATUS, 8'h07);
      rdc("ctrl one", ADDR_CTRL_ONE, 8'h38);
      rdc("ctrl two", ADDR_CTRL_TWO, 8'h20);
      rdc("baud", ADDR_BAUD, 8'h01);
      repeat (400) @(posedge pclk);
      c0 = count;
      wr(ADDR_CTRL_ONE, 8'hB8);
      wr(ADDR_CTRL_TWO, 8'hE0);
      repeat (300) @(posedge pclk);
      chk("frames", c0, count);
      send_chk(8'hB8, 8'h07, 8, 2, 32, 9'h007);
   endtask

   // Break holds the line low until cleared, then stop bits follow
   task t_break;
      wr(ADDR_CTRL_ONE, 8'hBC);
      repeat (300) @(posedge pclk);
      chk("break line", 0, serial_out_pin);
      wr(ADDR_CTRL_ONE, 8'hB8);
      repeat (500) @(posedge pclk);
      chk("break end", 1, serial_out_pin);
   endtask

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      bit_len = 16;
      nbits = 8;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_formats;
      t_buffer;
      t_late_enable;
      t_abort;
      t_break;
      apb(1'b0, 8'h20, 32'h0);
      chk("slave error", 1, err);
      end_sim;
   end
endmodule

/* File: testbench/uart_line_model.sv */
// Remote serial receiver that decodes frames seen on the transmit line
`timescale 1ns/1ps
module uart_line_model
(
   // Clock and lines
   input wire logic pclk,
   input wire logic line,
   output logic rx_line,
   // Frame format set by the bench
   input var int bit_len,
   input var int nbits,
   // Last decoded frame
   output logic [8:0] got,
   output int count
);
   initial
   begin
      rx_line = 1'b1;
      got = 9'h000;
      count = 0;
      forever
      begin
         @(negedge line);
         repeat (bit_len / 2) @(posedge pclk);
         if (line === 1'b0)
         begin
            got = 9'h000;
            for (int i = 0; i < nbits; i++)
            begin
               repeat (bit_len) @(posedge pclk);
               got[i] = line;
            end
            // Mid stop bit
            repeat (bit_len) @(posedge pclk);
            count++;
         end
      end
   end
endmodule
